/* design/tvdx_pkg.sv */
// Purpose: Shared constants and types for the trap vector, delegation and
//          extension status unit.
// Assumes: 32-bit native register width, AXI4-Lite register access.
// Notes:   Offsets are byte addresses within an 8-bit register window.
package tvdx_pkg;

    // ************************************************************
    // Widths, privilege codes and status encoding
    // ************************************************************
    localparam int          XW         = 32;
    localparam logic [1:0]  PRIV_U     = 2'h0;
    localparam logic [1:0]  PRIV_S     = 2'h1;
    localparam logic [1:0]  PRIV_H     = 2'h2;
    localparam logic [1:0]  PRIV_M     = 2'h3;
    localparam logic [1:0]  ST_OFF     = 2'h0;
    localparam logic [1:0]  ST_INITIAL = 2'h1;
    localparam logic [1:0]  ST_CLEAN   = 2'h2;
    localparam logic [1:0]  ST_DIRTY   = 2'h3;

    // Privilege mode sets the unit can be built for
    typedef enum {CFG_M_ONLY, CFG_MU, CFG_MU_UTRAP, CFG_MSU, CFG_MHSU} tvdx_cfg_type;
    localparam tvdx_cfg_type CFG = CFG_MSU;

    // ************************************************************
    // Register map (byte offsets) and field positions
    // ************************************************************
    localparam logic [7:0]  A_STATUS   = 8'h00;
    localparam logic [7:0]  A_EXTLOCAL = 8'h04;
    localparam logic [7:0]  A_MEDELEG  = 8'h0C;
    localparam logic [7:0]  A_MIDELEG  = 8'h10;
    localparam logic [7:0]  A_HEDELEG  = 8'h14;
    localparam logic [7:0]  A_HIDELEG  = 8'h18;
    localparam logic [7:0]  A_SEDELEG  = 8'h1C;
    localparam logic [7:0]  A_SIDELEG  = 8'h20;
    localparam logic [3:0]  A_CAUSE_HI = 4'h4;
    localparam logic [3:0]  A_EPC_HI   = 4'h5;
    localparam logic [3:0]  A_TVEC_HI  = 4'h6;
    localparam int          F_IE       = 0;
    localparam int          F_PIE      = 4;
    localparam int          F_FS       = 13;
    localparam int          F_XS       = 15;
    localparam int          F_PP       = 18;
    localparam int          F_SD       = 31;
    localparam logic [31:0] EXC_DELEG_MASK = 32'h0000FFFF;
    localparam logic [31:0] INT_DELEG_MASK = 32'h00000777;
    localparam logic [31:0] TVEC_RESET     = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef enum logic [2:0] {
        OP_READ, OP_MODIFY, OP_UNCONFIG, OP_DISABLE, OP_ENABLE
    } tvdx_op_type;

    typedef struct packed {
        logic        valid;
        logic        unit;   // 0 floating point, 1 other extension
        tvdx_op_type kind;
    } tvdx_ext_op_type;

    typedef struct packed {
        logic        valid;
        logic        is_int;
        logic [4:0]  code;
        logic [31:0] pc;
        logic [1:0]  priv;
    } tvdx_trap_type;

endpackage : tvdx_pkg

/* design/tvdx_trap_unit.sv */
// Purpose: Trap vector base, trap delegation and extension status tracking.
// Assumes: Synchronous active-low reset, AXI4-Lite slave, one hart clock.
// Notes:   Hardware events win over a software write in the same cycle.
//
// Summary of operation
// - Status fields are two bits: Off, Initial, Clean, Dirty.
// - Dirty summary is one when either status field holds Dirty.
// - Read faults when Off; modify faults when Off, else goes Dirty.
// - Unconfigure faults when Off else Initial; disable gives Off; enable Initial.
// - One shared copy of the status fields for all privilege modes.
// - A native-width machine trap vector base register always exists.
// - Trap vector base is word aligned, low two bits read zero.
// - Vector base read value equals the value used for the handler address.
// - Machine-mode traps load the program counter with the vector base.
// - Undelegated traps go to machine mode; delegation bits are read/write.
// - Four modes: machine delegation routes U/S/H traps to hypervisor.
// - Hypervisor delegation routes onward to supervisor, supervisor's to user.
// - Three modes: machine delegation routes S/U traps to supervisor.
// - Machine and user with user traps: delegation routes user traps to user.
// - Machine only, or no user traps: machine delegation is hardwired zero.
// - Delegated trap writes target cause and exception PC.
// - Delegated trap stacks mode and enable; machine fields stay untouched.
// - No delegation bit reads one unless supported and written; hedeleg, hideleg, sedeleg and sideleg keep fixed masks in every build.
// - Exception bits follow cause codes; interrupt bits follow pending layout.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module tvdx_trap_unit (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [7:0]                awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [7:0]                araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire tvdx_pkg::tvdx_ext_op_type op_in,
    output logic                           op_done,
    output logic                           op_fault,
    input  wire tvdx_pkg::tvdx_trap_type   trap_in,
    output logic                           trap_taken,
    output logic [1:0]                     trap_mode,
    output logic [31:0]                    trap_pc,
    output logic                           dirty_summary
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic             awready, wready, bvalid, arready, rvalid;
        logic [1:0]       bresp, rresp;
        logic [31:0]      rdata;
        logic             aw_held, w_held;
        logic [7:0]       aw_addr;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic [1:0]       fs, xs;
        logic             dirty;
        logic [3:0]       ie, pie;
        logic [3:0][1:0]  pp;
        logic [31:0]      medeleg, mideleg, hedeleg, hideleg, sedeleg, sideleg;
        logic [3:0][31:0] cause, epc, tvec;
        logic             op_done, op_fault, trap_taken;
        logic [1:0]       trap_mode;
        logic [31:0]      trap_pc;
    } tvdx_state_type;

    tvdx_state_type s_reg;
    tvdx_state_type s_next;
    logic [1:0]     op_cur;
    logic [1:0]     trap_tgt;

    // ************************************************************
    // Functions
    // ************************************************************
    // Supported delegation bits; none at all without a lower trap handler
    function automatic logic [31:0] deleg_mask(input logic is_int);
        logic [31:0] m;
        m = is_int ? tvdx_pkg::INT_DELEG_MASK : tvdx_pkg::EXC_DELEG_MASK;
        if (tvdx_pkg::CFG == tvdx_pkg::CFG_M_ONLY || tvdx_pkg::CFG == tvdx_pkg::CFG_MU) begin
            m = '0;
        end
        return m;
    endfunction : deleg_mask

    // Status transition for one instruction class: {fault, next status}
    function automatic logic [2:0] status_step(input logic [1:0] cur,
                                               input tvdx_pkg::tvdx_op_type kind);
        logic       off;
        logic [2:0] r;
        off = (cur == tvdx_pkg::ST_OFF);
        r   = {1'b0, cur};
        unique case (kind)
            tvdx_pkg::OP_READ:     r = {off, cur};
            tvdx_pkg::OP_MODIFY:   r = off ? {1'b1, cur} : {1'b0, tvdx_pkg::ST_DIRTY};
            tvdx_pkg::OP_UNCONFIG: r = off ? {1'b1, cur} : {1'b0, tvdx_pkg::ST_INITIAL};
            tvdx_pkg::OP_DISABLE:  r = {1'b0, tvdx_pkg::ST_OFF};
            tvdx_pkg::OP_ENABLE:   r = {1'b0, tvdx_pkg::ST_INITIAL};
            default:               r = {1'b0, cur};
        endcase
        return r;
    endfunction : status_step

    // Target mode of a trap; delegation bit index is the cause code
    function automatic logic [1:0] route(input logic [1:0] priv, input logic [4:0] code,
                                         input logic [31:0] md, input logic [31:0] hd,
                                         input logic [31:0] sd);
        logic [1:0] t;
        t = tvdx_pkg::PRIV_M;
        if (tvdx_pkg::CFG == tvdx_pkg::CFG_MHSU && priv != tvdx_pkg::PRIV_M && md[code]) begin
            t = tvdx_pkg::PRIV_H;
            if (priv <= tvdx_pkg::PRIV_S && hd[code]) begin
                t = tvdx_pkg::PRIV_S;
                if (priv == tvdx_pkg::PRIV_U && sd[code]) begin
                    t = tvdx_pkg::PRIV_U;
                end
            end
        end else if (tvdx_pkg::CFG == tvdx_pkg::CFG_MSU && priv <= tvdx_pkg::PRIV_S
                     && md[code]) begin
            t = tvdx_pkg::PRIV_S;
            if (priv == tvdx_pkg::PRIV_U && sd[code]) begin
                t = tvdx_pkg::PRIV_U;
            end
        end else if (tvdx_pkg::CFG == tvdx_pkg::CFG_MU_UTRAP && priv == tvdx_pkg::PRIV_U
                     && md[code]) begin
            t = tvdx_pkg::PRIV_U;
        end
        return t;
    endfunction : route

    // Register read decode: {hit, data}
    function automatic logic [32:0] reg_read(input tvdx_state_type st, input logic [7:0] a);
        logic [31:0] d;
        logic        hit;
        d   = '0;
        hit = 1'b1;
        case (a)
            tvdx_pkg::A_STATUS: begin
                d[tvdx_pkg::F_IE +: 4]  = st.ie;
                d[tvdx_pkg::F_PIE +: 4] = st.pie;
                d[tvdx_pkg::F_FS +: 2]  = st.fs;
                d[tvdx_pkg::F_XS +: 2]  = st.xs;
                d[tvdx_pkg::F_PP +: 8]  = st.pp;
                d[tvdx_pkg::F_SD]       = st.dirty;
            end
            tvdx_pkg::A_EXTLOCAL: d[1:0] = st.xs;
            tvdx_pkg::A_MEDELEG:  d = st.medeleg;
            tvdx_pkg::A_MIDELEG:  d = st.mideleg;
            tvdx_pkg::A_HEDELEG:  d = st.hedeleg;
            tvdx_pkg::A_HIDELEG:  d = st.hideleg;
            tvdx_pkg::A_SEDELEG:  d = st.sedeleg;
            tvdx_pkg::A_SIDELEG:  d = st.sideleg;
            default: begin
                if (a[7:4] == tvdx_pkg::A_CAUSE_HI) begin
                    d = st.cause[a[3:2]];
                end else if (a[7:4] == tvdx_pkg::A_EPC_HI) begin
                    d = st.epc[a[3:2]];
                end else if (a[7:4] == tvdx_pkg::A_TVEC_HI) begin
                    d = st.tvec[a[3:2]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
        return {hit, d};
    endfunction : reg_read

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Status of the unit the current instruction uses, and the trap target
    assign op_cur   = op_in.unit ? s_reg.xs : s_reg.fs;
    assign trap_tgt = route(trap_in.priv, trap_in.code,
                            trap_in.is_int ? s_reg.mideleg : s_reg.medeleg,
                            trap_in.is_int ? s_reg.hideleg : s_reg.hedeleg,
                            trap_in.is_int ? s_reg.sideleg : s_reg.sedeleg);

    // Bus handshakes, register writes, instruction events and traps
    always_comb begin
        logic [32:0] rd;
        logic [31:0] wv;
        logic [2:0]  step;
        logic        ii;
        rd     = '0;
        wv     = '0;
        step   = '0;
        ii     = 1'b0;
        s_next = s_reg;
        s_next.op_done    = 1'b0;
        s_next.op_fault   = 1'b0;
        s_next.trap_taken = 1'b0;
        if (awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            rd = reg_read(s_reg, s_reg.aw_addr);
            for (int i = 0; i < 4; i++) begin
                wv[i*8 +: 8] = s_reg.w_strb[i] ? s_reg.w_data[i*8 +: 8] : rd[i*8 +: 8];
            end
            s_next.bvalid  = 1'b1;
            s_next.bresp   = rd[32] ? tvdx_pkg::RESP_OKAY : tvdx_pkg::RESP_SLVERR;
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            case (s_reg.aw_addr)
                tvdx_pkg::A_STATUS: begin
                    s_next.ie  = wv[tvdx_pkg::F_IE +: 4];
                    s_next.pie = wv[tvdx_pkg::F_PIE +: 4];
                    s_next.fs  = wv[tvdx_pkg::F_FS +: 2];
                    s_next.pp  = wv[tvdx_pkg::F_PP +: 8];
                end
                tvdx_pkg::A_EXTLOCAL: s_next.xs = wv[1:0];
                tvdx_pkg::A_MEDELEG:  s_next.medeleg = wv & deleg_mask(1'b0);
                tvdx_pkg::A_MIDELEG:  s_next.mideleg = wv & deleg_mask(1'b1);
                tvdx_pkg::A_HEDELEG:  s_next.hedeleg = wv & tvdx_pkg::EXC_DELEG_MASK;
                tvdx_pkg::A_HIDELEG:  s_next.hideleg = wv & tvdx_pkg::INT_DELEG_MASK;
                tvdx_pkg::A_SEDELEG:  s_next.sedeleg = wv & tvdx_pkg::EXC_DELEG_MASK;
                tvdx_pkg::A_SIDELEG:  s_next.sideleg = wv & tvdx_pkg::INT_DELEG_MASK;
                default: begin
                    if (s_reg.aw_addr[7:4] == tvdx_pkg::A_CAUSE_HI) begin
                        s_next.cause[s_reg.aw_addr[3:2]] = wv;
                    end else if (s_reg.aw_addr[7:4] == tvdx_pkg::A_EPC_HI) begin
                        s_next.epc[s_reg.aw_addr[3:2]] = wv;
                    end else if (s_reg.aw_addr[7:4] == tvdx_pkg::A_TVEC_HI) begin
                        s_next.tvec[s_reg.aw_addr[3:2]] = {wv[31:2], 2'h0};
                    end
                end
            endcase
        end
        // Read channel answers one cycle after the address is taken
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            rd            = reg_read(s_reg, araddr);
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd[31:0];
            s_next.rresp  = rd[32] ? tvdx_pkg::RESP_OKAY : tvdx_pkg::RESP_SLVERR;
        end
        // Extension instruction moves the shared status field
        if (op_in.valid) begin
            step            = status_step(op_cur, op_in.kind);
            s_next.op_done  = 1'b1;
            s_next.op_fault = step[2];
            if (op_in.unit) begin
                s_next.xs = step[1:0];
            end else begin
                s_next.fs = step[1:0];
            end
        end
        // Trap entry into the routed mode only
        if (trap_in.valid) begin
            ii                      = s_reg.ie[trap_in.priv];
            s_next.cause[trap_tgt]  = {trap_in.is_int, 26'h0000000, trap_in.code};
            s_next.epc[trap_tgt]    = trap_in.pc;
            s_next.pp[trap_tgt]     = trap_in.priv;
            s_next.pie[trap_tgt]    = ii;
            s_next.ie[trap_tgt]     = 1'b0;
            s_next.trap_taken       = 1'b1;
            s_next.trap_mode        = trap_tgt;
            s_next.trap_pc          = s_reg.tvec[trap_tgt];
        end
        s_next.tvec[3][1:0] = 2'h0;
        s_next.dirty   = (s_next.fs == tvdx_pkg::ST_DIRTY) || (s_next.xs == tvdx_pkg::ST_DIRTY);
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready  = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    // State register; vector base always present and aligned
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg         <= '0;
            s_reg.tvec[3] <= tvdx_pkg::TVEC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign awready       = s_reg.awready;
    assign wready        = s_reg.wready;
    assign bvalid        = s_reg.bvalid;
    assign bresp         = s_reg.bresp;
    assign arready       = s_reg.arready;
    assign rvalid        = s_reg.rvalid;
    assign rdata         = s_reg.rdata;
    assign rresp         = s_reg.rresp;
    assign op_done       = s_reg.op_done;
    assign op_fault      = s_reg.op_fault;
    assign trap_taken    = s_reg.trap_taken;
    assign trap_mode     = s_reg.trap_mode;
    assign trap_pc       = s_reg.trap_pc;
    assign dirty_summary = s_reg.dirty;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dirty;
        dirty_summary == (s_reg.fs == 2'h3 || s_reg.xs == 2'h3);
    endproperty
    a_dirty: assert property (p_dirty) else $error("dirty summary wrong");

    property p_read_off;
        op_in.valid && op_in.kind == tvdx_pkg::OP_READ |=> op_fault == ($past(op_cur) == 2'h0);
    endproperty
    a_read_off: assert property (p_read_off) else $error("read fault wrong");

    property p_modify;
        op_in.valid && op_in.kind == tvdx_pkg::OP_MODIFY && op_cur != 2'h0 && !op_in.unit
            |=> !op_fault && s_reg.fs == 2'h3 && dirty_summary;
    endproperty
    a_modify: assert property (p_modify) else $error("modify not dirty");

    property p_disable;
        op_in.valid && op_in.kind == tvdx_pkg::OP_DISABLE && op_in.unit
            |=> !op_fault && op_done && s_reg.xs == 2'h0;
    endproperty
    a_disable: assert property (p_disable) else $error("disable not off");

    property p_unconfig;
        op_in.valid && op_in.kind == tvdx_pkg::OP_UNCONFIG && !op_in.unit
            |=> op_fault == ($past(op_cur) == 2'h0)
                && s_reg.fs == (op_fault ? 2'h0 : 2'h1);
    endproperty
    a_unconfig: assert property (p_unconfig) else $error("unconfigure wrong");

    property p_tvec_align;
        s_reg.tvec[3][1:0] == 2'h0;
    endproperty
    a_tvec_align: assert property (p_tvec_align) else $error("vector base misaligned");

    property p_machine_trap;
        trap_in.valid && trap_in.priv == 2'h3
            |=> trap_taken && trap_mode == 2'h3 && trap_pc == $past(s_reg.tvec[3]);
    endproperty
    a_machine_trap: assert property (p_machine_trap) else $error("machine trap pc");

    property p_deleg_keep_m;
        trap_in.valid && trap_tgt != 2'h3 && !(s_reg.aw_held && s_reg.w_held)
            |=> s_reg.cause[3] == $past(s_reg.cause[3]) && s_reg.epc[3] == $past(s_reg.epc[3])
                && s_reg.pp[3] == $past(s_reg.pp[3]) && s_reg.epc[trap_mode] == $past(trap_in.pc);
    endproperty
    a_deleg_keep_m: assert property (p_deleg_keep_m) else $error("delegated trap hit machine");

    property p_deleg_mask;
        (s_reg.medeleg & ~tvdx_pkg::EXC_DELEG_MASK) == 32'h00000000
            && (s_reg.mideleg & ~tvdx_pkg::INT_DELEG_MASK) == 32'h00000000;
    endproperty
    a_deleg_mask: assert property (p_deleg_mask) else $error("unsupported deleg bit");

endmodule : tvdx_trap_unit

/* dv/tvdx_testbench.sv */
// Purpose: Self-checking bench for the trap vector, delegation and status unit.
// Assumes: Machine, supervisor and user build; bready and rready held high.
// Notes:   Table rows pack {op kind[2:0], fault, expected float status[1:0]}.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      aclk    = 1'b0;
    logic                      aresetn = 1'b0;
    logic [7:0]                awaddr  = 8'h00;
    logic [7:0]                araddr  = 8'h00;
    logic                      awvalid = 1'b0;
    logic                      wvalid  = 1'b0;
    logic                      arvalid = 1'b0;
    logic                      bready  = 1'b1;
    logic                      rready  = 1'b1;
    logic [31:0]               wdata   = 32'h00000000;
    logic [3:0]                wstrb   = 4'hF;
    logic                      awready, wready, bvalid, arready, rvalid;
    logic                      op_done, op_fault, trap_taken, dirty_summary;
    logic [1:0]                bresp, rresp, trap_mode, r;
    logic [31:0]               rdata, trap_pc, d;
    tvdx_pkg::tvdx_ext_op_type op_in   = '0;
    tvdx_pkg::tvdx_trap_type   trap_in = '0;
    int                        errors  = 0;
    int                        n_compared = 0;
    logic [5:0]                tbl [8];

    tvdx_trap_unit tvdx_trap_unit_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .op_in, .op_done, .op_fault, .trap_in,
        .trap_taken, .trap_mode, .trap_pc, .dirty_summary);

    // ************************************************************
    // Clock, checks and bus tasks
    // ************************************************************
    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic test_done;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        if (n == 50) errors++;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        if (n == 50) errors++;
    endtask : rd

    task automatic op(input logic u, input logic [2:0] k);
        op_in <= '{1'b1, u, tvdx_pkg::tvdx_op_type'(k)};
        @(posedge aclk);
        op_in.valid <= 1'b0;
        #1;
        chk({31'h0, op_done}, 32'h1, "op done");
    endtask : op

    task automatic trap(input logic [1:0] p, input logic [4:0] c, input logic [31:0] pc);
        trap_in <= '{1'b1, 1'b0, c, pc, p};
        @(posedge aclk);
        trap_in.valid <= 1'b0;
        #1;
        chk({31'h0, trap_taken}, 32'h1, "trap taken");
    endtask : trap

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        #100us;
        errors++;
        test_done();
    end

    initial begin
        tbl = '{6'h04, 6'h0C, 6'h14, 6'h21, 6'h01, 6'h0B, 6'h11, 6'h18};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h08);
        chk({30'h0, r}, {30'h0, tvdx_pkg::RESP_SLVERR}, "unmapped read resp");
        chk(d, 32'h0, "unmapped read data");
        wr(8'h08, 32'hFFFFFFFF);
        chk({30'h0, r}, {30'h0, tvdx_pkg::RESP_SLVERR}, "unmapped write resp");
        // Float unit walked through every instruction kind
        for (int i = 0; i < 8; i++) begin
            op(1'b0, tbl[i][5:3]);
            chk({31'h0, op_fault}, {31'h0, tbl[i][2]}, "op fault");
            rd(tvdx_pkg::A_STATUS);
            chk({30'h0, d[14:13]}, {30'h0, tbl[i][1:0]}, "float status");
            chk({31'h0, d[31]}, {31'h0, tbl[i][1:0] == 2'h3}, "dirty bit");
        end
        wr(tvdx_pkg::A_STATUS, 32'h00004000);
        op(1'b0, 3'h0);
        rd(tvdx_pkg::A_STATUS);
        chk({30'h0, d[14:13]}, 32'h2, "read keeps clean");
        op(1'b1, 3'h4);
        op(1'b1, 3'h1);
        chk({31'h0, dirty_summary}, 32'h1, "ext dirty summary");
        rd(tvdx_pkg::A_STATUS);
        chk({30'h0, d[16:15]}, 32'h3, "ext status dirty");
        // Machine vector base and an undelegated trap
        wr(8'h6C, 32'h12345677);
        chk({30'h0, r}, 32'h0, "write resp okay");
        rd(8'h6C);
        chk(d, 32'h12345674, "vector base aligned");
        trap(tvdx_pkg::PRIV_U, 5'h02, 32'h00000200);
        chk({30'h0, trap_mode}, 32'h3, "trap to machine");
        chk(trap_pc, 32'h12345674, "machine handler pc");
        // Delegation masks and a delegated environment call
        wr(tvdx_pkg::A_MEDELEG, 32'hFFFFFFFF);
        rd(tvdx_pkg::A_MEDELEG);
        chk(d, tvdx_pkg::EXC_DELEG_MASK, "exception deleg mask");
        wr(tvdx_pkg::A_MIDELEG, 32'hFFFFFFFF);
        rd(tvdx_pkg::A_MIDELEG);
        chk(d, tvdx_pkg::INT_DELEG_MASK, "interrupt deleg mask");
        wr(8'h64, 32'h00000101);
        wr(tvdx_pkg::A_STATUS, 32'h00000001);
        trap(tvdx_pkg::PRIV_U, 5'h08, 32'h00000ABC);
        chk({30'h0, trap_mode}, 32'h1, "trap to supervisor");
        chk(trap_pc, 32'h00000100, "supervisor handler pc");
        rd(8'h44);
        chk(d, 32'h00000008, "supervisor cause");
        rd(8'h54);
        chk(d, 32'h00000ABC, "supervisor epc");
        rd(tvdx_pkg::A_STATUS);
        chk(d & 32'h03FC00FF, 32'h00000021, "status stack");
        rd(8'h4C);
        chk(d, 32'h00000002, "machine cause kept");
        rd(8'h5C);
        chk(d, 32'h00000200, "machine epc kept");
        test_done();
    end
endmodule : testbench
